// ---- src/ide_dma_mode_and_write_hold_ctrl.sv ----
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "ide_mode_consts.svh"

// Operation
// - Read-write bit 0 of the ultra-DMA select register enables ultra-DMA for drive 0.
// - Read-write bit 1 of the ultra-DMA select register enables ultra-DMA for drive 1.
// - A drive whose ultra-DMA bit is clear does its DMA transfers as multiword DMA.
// - Slave write data is held for bits 22-20 plus one cycles after the write strobe ends.
// - Master write data is held for bits 18-16 plus one cycles after the write strobe ends.
// - The same per-drive hold applies to 8-bit PIO, 16-bit PIO and multiword DMA writes.
// - The hold fields matter only while the timing override bit is one.
// - With the override bit at zero all timing comes from built-in parameters.
// - With the override bit at one the hold, and the strobe of 8-bit writes only, come from the programmable override registers.
// - Under override an 8-bit task file strobe lasts its drive's field plus one cycles.
module ide_dma_mode_and_write_hold_ctrl #(
   parameter int ADDR_W = 12
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic reset,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire ide_mode_pkg::word_t pwdata,
   output ide_mode_pkg::word_t prdata,
   output logic pready,
   output logic pslverr,
   // Drive interface.
   output logic hostWriteStrobe,
   output logic writeDataHeld,
   output logic ultraModeActive,
   output logic xferDone
);
   import ide_mode_pkg::*;

   word_t ultraSel_reg;
   word_t miscCtrl_reg;
   word_t tfStrobe_reg;
   logic startDrive_reg;
   xfer_kind_e startKind_reg;
   logic startPulse_reg;
   logic busy_reg;
   logic doneSticky_reg;
   logic [6:0] strobeLen_reg;
   logic [2:0] holdLen_reg;

   // Bus decode.
   wire logic setupPhase = psel && !penable;
   wire logic accessPhase = psel && penable;
   wire logic hitUltra = (paddr == `ADDR_ULTRA_SEL);
   wire logic hitMisc = (paddr == `ADDR_MISC_CTRL);
   wire logic hitStrobe = (paddr == `ADDR_TF_STROBE);
   wire logic hitXfer = (paddr == `ADDR_XFER_CTRL);
   wire logic hitStat = (paddr == `ADDR_XFER_STAT);
   wire logic hitAny = hitUltra | hitMisc | hitStrobe | hitXfer | hitStat;
   // Writes land at the access edge where the master sees pready, never earlier.
   wire logic wrEn = accessPhase && pready && pwrite && hitAny;
   wire logic xferWrite = wrEn && hitXfer;

   // Register view of per-drive settings.
   wire logic overrideOn = miscCtrl_reg[`BIT_OVERRIDE];
   wire logic ultra0 = ultraSel_reg[`BIT_DRIVE0_ULTRA];
   wire logic ultra1 = ultraSel_reg[`BIT_DRIVE1_ULTRA];
   wire logic [2:0] masterHold = miscCtrl_reg[`MASTER_HOLD_MSB:`MASTER_HOLD_LSB];
   wire logic [2:0] slaveHold = miscCtrl_reg[`SLAVE_HOLD_MSB:`SLAVE_HOLD_LSB];
   wire logic [6:0] masterStb = tfStrobe_reg[`MASTER_STB_MSB:`MASTER_STB_LSB];
   wire logic [6:0] slaveStb = tfStrobe_reg[`SLAVE_STB_MSB:`SLAVE_STB_LSB];

   // Write-command fields: bit 0 drive select, bits 2:1 transfer kind.
   wire logic cmdDrive = pwdata[0];
   wire xfer_kind_e cmdKind = xfer_kind_e'(pwdata[2:1]);

   // Picks the addressed drive's value of a setting.
   function automatic logic [6:0] pick7(input logic drive, input logic [6:0] m,
                                        input logic [6:0] s);
      pick7 = drive ? s : m;
   endfunction

   wire logic [6:0] selStb = pick7(cmdDrive, masterStb, slaveStb);
   wire logic [6:0] selHold7 = pick7(cmdDrive, {4'h0, masterHold}, {4'h0, slaveHold});

   // Strobe length: override field only for 8-bit task file writes.
   wire logic [6:0] strobeNext = (overrideOn && cmdKind == KIND_PIO8) ?
                                 selStb : `INT_STROBE_CYCLES;
   // Hold length: same field for every write kind while override is set.
   wire logic [2:0] holdNext = overrideOn ?
                               selHold7[2:0] : `INT_HOLD_CYCLES;

   // Ultra mode for the addressed drive, else multiword DMA.
   wire logic ultraNext = (cmdKind == KIND_DMA) &&
                          (cmdDrive ? ultra1 : ultra0);

   wire logic timerStrobe;
   wire logic timerHeld;
   wire logic timerDone;

   ide_write_timer #(
      .STB_W(7),
      .HOLD_W(3)
   ) writeTimer (
      .clock(clock),
      .reset(reset),
      .start(startPulse_reg),
      .strobeLen(strobeLen_reg),
      .holdLen(holdLen_reg),
      .strobeOn(timerStrobe),
      .dataHeld(timerHeld),
      .done(timerDone)
   );

   // A new write is taken only when the timer is idle.
   wire logic launch = xferWrite && !busy_reg;

   wire word_t statusWord = {29'h0, ultraModeActive, doneSticky_reg, busy_reg};
   wire word_t readMux = hitUltra ? ultraSel_reg :
                         hitMisc ? miscCtrl_reg :
                         hitStrobe ? tfStrobe_reg :
                         hitXfer ? {29'h0, startKind_reg, startDrive_reg} :
                         hitStat ? statusWord : 32'h0000_0000;

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         ultraSel_reg <= `REG_RESET;
         miscCtrl_reg <= `REG_RESET;
         tfStrobe_reg <= `REG_RESET;
      end else if (wrEn) begin
         if (hitUltra) begin
            ultraSel_reg <= pwdata & `ULTRA_SEL_MASK;
         end
         if (hitMisc) begin
            miscCtrl_reg <= pwdata & `MISC_CTRL_MASK;
         end
         if (hitStrobe) begin
            tfStrobe_reg <= pwdata & `TF_STROBE_MASK;
         end
      end
   end

   // Settings are latched at launch so a register write mid-cycle cannot bend timing.
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         startDrive_reg <= 1'b0;
         startKind_reg <= KIND_PIO8;
         startPulse_reg <= 1'b0;
         strobeLen_reg <= 7'h00;
         holdLen_reg <= 3'h0;
         ultraModeActive <= 1'b0;
      end else begin
         startPulse_reg <= launch;
         if (launch) begin
            startDrive_reg <= cmdDrive;
            startKind_reg <= cmdKind;
            strobeLen_reg <= strobeNext;
            holdLen_reg <= holdNext;
            ultraModeActive <= ultraNext;
         end
      end
   end

   // Busy from launch to done; done sticks until the next launch, which a new event beats.
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         busy_reg <= 1'b0;
         doneSticky_reg <= 1'b0;
      end else begin
         busy_reg <= launch | (busy_reg & !timerDone);
         doneSticky_reg <= timerDone | (doneSticky_reg & !launch);
      end
   end

   // Outputs, each from a flip-flop.
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         hostWriteStrobe <= 1'b0;
         writeDataHeld <= 1'b0;
         xferDone <= 1'b0;
      end else begin
         pready <= setupPhase;
         pslverr <= setupPhase && !hitAny;
         if (setupPhase && !pwrite) begin
            prdata <= readMux;
         end
         hostWriteStrobe <= timerStrobe;
         writeDataHeld <= timerHeld;
         xferDone <= timerDone;
      end
   end
endmodule

// ---- src/ide_mode_consts.svh ----
`ifndef IDE_MODE_CONSTS_SVH
`define IDE_MODE_CONSTS_SVH

// Byte addresses of the registers on the APB.
`define ADDR_ULTRA_SEL 12'h000
`define ADDR_MISC_CTRL 12'h004
`define ADDR_TF_STROBE 12'h008
`define ADDR_XFER_CTRL 12'h00c
`define ADDR_XFER_STAT 12'h010

// Field positions.
`define BIT_DRIVE0_ULTRA 0
`define BIT_DRIVE1_ULTRA 1
`define BIT_OVERRIDE 0
`define MASTER_HOLD_LSB 16
`define MASTER_HOLD_MSB 18
`define SLAVE_HOLD_LSB 20
`define SLAVE_HOLD_MSB 22
`define MASTER_STB_LSB 0
`define MASTER_STB_MSB 6
`define SLAVE_STB_LSB 8
`define SLAVE_STB_MSB 14

// Masks of writable bits and reset values.
`define ULTRA_SEL_MASK 32'h0000_0003
`define MISC_CTRL_MASK 32'h0077_0001
`define TF_STROBE_MASK 32'h0000_7f7f
`define REG_RESET 32'h0000_0000

// Built-in timing used when the override bit is clear.
`define INT_STROBE_CYCLES 7'h0b
`define INT_HOLD_CYCLES 3'h2

`endif

// ---- src/ide_mode_pkg.sv ----
package ide_mode_pkg;
   typedef logic [31:0] word_t;
   typedef enum logic [1:0] {
      KIND_PIO8 = 2'b00,
      KIND_PIO16 = 2'b01,
      KIND_DMA = 2'b10
   } xfer_kind_e;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_STROBE = 2'b01,
      ST_HOLD = 2'b10
   } wr_state_e;
endpackage

// ---- src/ide_write_timer.sv ----
`timescale 1ns/10ps
`include "ide_mode_consts.svh"

// Runs one write cycle: strobe for strobeLen+1 cycles, then hold data holdLen+1 cycles.
module ide_write_timer #(
   parameter int STB_W = 7,
   parameter int HOLD_W = 3
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic reset,
   // Start and lengths, sampled on start.
   input wire logic start,
   input wire logic [STB_W-1:0] strobeLen,
   input wire logic [HOLD_W-1:0] holdLen,
   // Status.
   output logic strobeOn,
   output logic dataHeld,
   output logic done
);
   import ide_mode_pkg::*;

   wr_state_e state_reg;
   wr_state_e state_next;
   logic [STB_W-1:0] count_reg;
   logic [STB_W-1:0] count_next;
   logic [HOLD_W-1:0] hold_reg;
   logic [HOLD_W-1:0] hold_next;
   logic done_next;

   always_comb begin
      state_next = state_reg;
      count_next = count_reg;
      hold_next = hold_reg;
      done_next = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            if (start) begin
               state_next = ST_STROBE;
               count_next = strobeLen;
               hold_next = holdLen;
            end
         end
         ST_STROBE: begin
            if (count_reg == '0) begin
               state_next = ST_HOLD;
               count_next = STB_W'(hold_reg);
            end else begin
               count_next = count_reg - 1'b1;
            end
         end
         ST_HOLD: begin
            if (count_reg == '0) begin
               state_next = ST_IDLE;
               done_next = 1'b1;
            end else begin
               count_next = count_reg - 1'b1;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state_reg <= ST_IDLE;
         count_reg <= '0;
         hold_reg <= '0;
         strobeOn <= 1'b0;
         dataHeld <= 1'b0;
         done <= 1'b0;
      end else begin
         state_reg <= state_next;
         count_reg <= count_next;
         hold_reg <= hold_next;
         strobeOn <= (state_next == ST_STROBE);
         dataHeld <= (state_next != ST_IDLE);
         done <= done_next;
      end
   end
endmodule

// ---- bench/ide_ctrl_props.sv ----
`timescale 1ns/10ps
module ide_ctrl_props #(
   parameter int ADDR_W = 12
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic reset,
   // APB.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire ide_mode_pkg::word_t pwdata,
   input wire ide_mode_pkg::word_t prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Drive side.
   input wire logic hostWriteStrobe,
   input wire logic writeDataHeld,
   input wire logic ultraModeActive,
   input wire logic xferDone
);
   wire launch = psel && penable && pready && pwrite && paddr == 12'h00c;
   default clocking @(posedge clock);
   endclocking
   default disable iff (reset);
   answer_next_a: assert property (psel && !penable |=> pready)
      else $error("no answer after setup");
   answer_pulse_a: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   error_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   launch_start_a: assert property (
      launch && !writeDataHeld && !xferDone && !$past(launch) && !$past(launch, 2)
      |-> ##3 $rose(hostWriteStrobe)) else $error("write strobe did not start");
   held_strobe_a: assert property (hostWriteStrobe |-> writeDataHeld)
      else $error("data not held under strobe");
   hold_min_a: assert property ($fell(hostWriteStrobe) |-> writeDataHeld)
      else $error("no hold after strobe");
   hold_max_a: assert property ($fell(hostWriteStrobe) |-> ##[1:8] !writeDataHeld)
      else $error("hold longer than eight cycles");
   strobe_max_a: assert property ($rose(hostWriteStrobe) |-> ##[1:128] !hostWriteStrobe)
      else $error("strobe longer than 128 cycles");
   done_end_a: assert property ($fell(writeDataHeld) |-> ##[0:1] xferDone)
      else $error("no done at end of hold");
endmodule

bind ide_dma_mode_and_write_hold_ctrl ide_ctrl_props #(.ADDR_W(ADDR_W)) u_props (
   .clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .hostWriteStrobe(hostWriteStrobe), .writeDataHeld(writeDataHeld),
   .ultraModeActive(ultraModeActive), .xferDone(xferDone));

// ---- bench/ata_drive_model.sv ----
`timescale 1ns/10ps
// The drives only listen to these signals, so the model measures what it sees.
module ata_drive_model (
   // Clock.
   input wire logic clock,
   // Write signals at the drive.
   input wire logic hostWriteStrobe,
   input wire logic writeDataHeld,
   // Lengths of the last write.
   output int strobeCycles,
   output int holdCycles
);
   logic lastStrobe = 1'b0;
   always @(posedge clock) begin
      if (hostWriteStrobe)
         strobeCycles <= lastStrobe ? strobeCycles + 1 : 1;
      if (hostWriteStrobe && !lastStrobe)
         holdCycles <= 0;
      else if (writeDataHeld && !hostWriteStrobe)
         holdCycles <= holdCycles + 1;
      lastStrobe <= hostWriteStrobe;
   end
endmodule

// ---- bench/tb_ide_dma_mode_and_write_hold_ctrl.sv ----
`timescale 1ns/10ps
`include "ide_mode_consts.svh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
   $display("wrong value %s expected %h seen %h", n, e, g); end end
module tb_ide_dma_mode_and_write_hold_ctrl;
   import ide_mode_pkg::*;
   logic clock = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, err;
   logic [11:0] paddr = 12'h000;
   word_t pwdata = 32'h0000_0000, prdata, rd;
   logic pready, pslverr, hostWriteStrobe, writeDataHeld, ultraModeActive, xferDone;
   int n_fail = 0, check_count = 0, strobeCycles, holdCycles;
   always #2.5 clock = ~clock;
   ide_dma_mode_and_write_hold_ctrl dut (.clock(clock), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .hostWriteStrobe(hostWriteStrobe),
      .writeDataHeld(writeDataHeld), .ultraModeActive(ultraModeActive), .xferDone(xferDone));
   ata_drive_model drives (.clock(clock), .hostWriteStrobe(hostWriteStrobe),
      .writeDataHeld(writeDataHeld), .strobeCycles(strobeCycles), .holdCycles(holdCycles));
   task finish_test;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task apb(input logic wr, input logic [11:0] a, input word_t d);
      int i;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge clock);
         i++;
      end while (pready !== 1'b1 && i < 20);
      if (pready !== 1'b1) begin
         n_fail++;
         finish_test;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask
   // Launches one write, tries a second launch while busy, then checks the measured timing.
   task launch(input logic drv, input xfer_kind_e kind, input int s, input int h,
      input logic ultra);
      word_t cmd;
      int i;
      cmd = {29'h0, kind, drv};
      apb(1'b1, `ADDR_XFER_CTRL, cmd);
      for (i = 0; hostWriteStrobe !== 1'b1 && i < 20; i++)
         @(posedge clock);
      if (hostWriteStrobe !== 1'b1) begin
         n_fail++;
         finish_test;
      end
      apb(1'b1, `ADDR_XFER_CTRL, cmd ^ 32'h0000_0001);
      apb(1'b0, `ADDR_XFER_CTRL, 32'h0000_0000);
      `CHK("command", cmd, rd)
      for (i = 0; xferDone !== 1'b1 && i < 300; i++)
         @(posedge clock);
      if (xferDone !== 1'b1) begin
         n_fail++;
         finish_test;
      end
      @(posedge clock);
      `CHK("strobe", s + 1, strobeCycles)
      `CHK("hold", h + 1, holdCycles)
      `CHK("ultra", ultra, ultraModeActive)
      apb(1'b0, `ADDR_XFER_STAT, 32'h0000_0000);
      `CHK("status", {29'h0, ultra, 2'b10}, rd)
   endtask
   initial begin
      repeat (8) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      apb(1'b0, `ADDR_ULTRA_SEL, 32'h0000_0000);
      `CHK("ultra reset", 32'h0000_0000, rd)
      apb(1'b0, `ADDR_MISC_CTRL, 32'h0000_0000);
      `CHK("misc reset", 32'h0000_0000, rd)
      apb(1'b1, `ADDR_ULTRA_SEL, 32'hffff_ffff);
      apb(1'b0, `ADDR_ULTRA_SEL, 32'h0000_0000);
      `CHK("ultra bits", 32'h0000_0003, rd)
      apb(1'b1, `ADDR_MISC_CTRL, 32'hffff_ffff);
      apb(1'b0, `ADDR_MISC_CTRL, 32'h0000_0000);
      `CHK("misc bits", 32'h0077_0001, rd)
      apb(1'b0, 12'h020, 32'h0000_0000);
      `CHK("unmapped error", 1'b1, err)
      `CHK("unmapped data", 32'h0000_0000, rd)
      apb(1'b1, `ADDR_ULTRA_SEL, 32'h0000_0000);
      apb(1'b1, `ADDR_MISC_CTRL, 32'h0077_0000);
      apb(1'b1, `ADDR_TF_STROBE, 32'h0000_0005);
      launch(1'b0, KIND_PIO8, 11, 2, 1'b0);
      apb(1'b1, `ADDR_MISC_CTRL, 32'h0073_0001);
      launch(1'b0, KIND_PIO8, 5, 3, 1'b0);
      launch(1'b1, KIND_PIO8, 0, 7, 1'b0);
      launch(1'b0, KIND_PIO16, 11, 3, 1'b0);
      apb(1'b1, `ADDR_ULTRA_SEL, 32'h0000_0002);
      launch(1'b1, KIND_DMA, 11, 7, 1'b1);
      launch(1'b0, KIND_DMA, 11, 3, 1'b0);
      apb(1'b1, `ADDR_ULTRA_SEL, 32'h0000_0001);
      launch(1'b0, KIND_DMA, 11, 3, 1'b1);
      apb(1'b1, `ADDR_ULTRA_SEL, 32'h0000_0000);
      launch(1'b1, KIND_DMA, 11, 7, 1'b0);
      finish_test;
   end
endmodule
